// *** verilog/nmt_params.svh ***
/*
  Constants of the network-management and error-control block: identifiers,
  command codes, state codes, object indices, reset values and timing counts.
  Assumes a 50 MHz node clock and a millisecond time base derived from it.
*/
`ifndef NMT_PARAMS_SVH
`define NMT_PARAMS_SVH

`define ID_NMT           11'h000
`define ID_ERRCTL_BASE   11'h700
`define CS_START         8'h01
`define CS_STOP          8'h02
`define CS_PREOP         8'h80
`define CS_RESET_APP     8'h81
`define CS_RESET_COMM    8'h82
`define ST_BOOT          7'h00
`define ST_STOPPED       7'h04
`define ST_OPER          7'h05
`define ST_PREOP         7'h7F
`define TOGGLE_BIT       7
`define OBJ_HB_PERIOD    16'h1017
`define OBJ_GUARD_TIME   16'h100C
`define OBJ_LIFE_FACTOR  16'h100D
`define HB_PERIOD_RESET  16'h0000
`define GUARD_RESET      16'h0000
`define LIFE_RESET       8'h00
`define CLK_HZ           50000000
`define TICK_MS          1
`define TICK_CYCLES      ((`CLK_HZ / 1000) * `TICK_MS)
`define INIT_CYCLES      16

`endif

// *** verilog/nmt_pkg.sv ***
/*
  Types of the network-management block: node states and frame carriers.
  Assumes the constants header is included by every user.
*/
package nmt_pkg;

  typedef enum logic [3:0] {
    S_INIT    = 4'b0001,
    S_PREOP   = 4'b0010,
    S_OPER    = 4'b0100,
    S_STOPPED = 4'b1000
  } node_state_t;

  typedef struct packed {
    logic [10:0] id;
    logic        rtr;
    logic [3:0]  dlc;
    logic [7:0]  data0;
    logic [7:0]  data1;
  } can_frame_t;

  typedef struct packed {
    logic [15:0] index;
    logic [15:0] data;
  } obj_write_t;

endpackage

// *** verilog/ms_tick.sv ***
/*
  Millisecond tick generator from the node clock.
  Assumes clk at 50 MHz and a global clock enable.
*/
`include "nmt_params.svh"
`timescale 1ns/100ps
`default_nettype none
module ms_tick
  import nmt_pkg::*;
(
  // Clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Tick out
  output logic      tick
);

  localparam int unsigned TC = `TICK_CYCLES;
  logic [15:0] count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (ce) begin
      tick <= (count == 16'(TC - 1));
      if (count == 16'(TC - 1)) begin
        count <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// *** verilog/ms_timer.sv ***
/*
  Millisecond down-counter with restart and expiry pulse.
  Assumes a one-cycle millisecond tick input.
*/
`include "nmt_params.svh"
`timescale 1ns/100ps
`default_nettype none
module ms_timer
  import nmt_pkg::*;
(
  // Clock and control
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        tick,
  // Control
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [23:0] period,
  // Status
  output logic             expired
);

  logic [23:0] remain;
  logic        running;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remain  <= 24'h00_0000;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (stop) begin
        running <= 1'b0;
      end else if (start) begin
        remain  <= period;
        running <= (period != 24'h00_0000);
      end else if (running && tick) begin
        if (remain <= 24'h00_0001) begin
          expired <= 1'b1;
          remain  <= period;
        end else begin
          remain <= remain - 24'h00_0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** verilog/canopen_nmt_error_control.sv ***
/*
  Network state machine, announcement, heartbeat producer and node-guarding
  of a CAN node. Receives decoded frames one per cycle from a CAN controller,
  requests transmit frames with a valid/ready handshake, and takes object
  writes for the error-control objects from the service-data layer.
  Assumes the master spaces network commands adequately.
*/
`include "nmt_params.svh"
`timescale 1ns/100ps
`default_nettype none
module canopen_nmt_error_control
  import nmt_pkg::*;
(
  // Clock and control
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Node configuration
  input  wire logic [6:0]  nodeId,
  input  wire logic        saveBusy,
  // Received frames
  input  wire can_frame_t  rxFrame,
  input  wire logic        rxValid,
  // Object writes and reads
  input  wire obj_write_t  objWrite,
  input  wire logic        objWriteValid,
  input  wire logic [15:0] objReadIndex,
  output logic [15:0]      objReadData,
  // Transmit request
  output can_frame_t       txFrame,
  output logic             txValid,
  input  wire logic        txReady,
  // State and permissions
  output logic [6:0]       nodeStateCode,
  output logic             sdoEnable,
  output logic             pdoEnable,
  output logic             appResetPulse,
  output logic             commResetPulse,
  output logic             guardError
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic addressedToMe(input can_frame_t f, input logic [6:0] nid);
    addressedToMe = (f.id == `ID_NMT) && !f.rtr && (f.dlc == 4'h2) &&
                    ((f.data1 == 8'h00) || (f.data1 == {1'b0, nid}));
  endfunction

  function automatic logic [6:0] stateCode(input node_state_t s);
    case (s)
      S_PREOP:   stateCode = `ST_PREOP;
      S_OPER:    stateCode = `ST_OPER;
      S_STOPPED: stateCode = `ST_STOPPED;
      default:   stateCode = `ST_BOOT;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  node_state_t state;
  node_state_t next_state;
  logic [4:0]  initCount;
  logic        bootPending;
  logic        pendAppReset;
  logic        toggleFlag;
  logic        guardArmed;
  logic        hbPending;
  logic        guardPending;
  logic [15:0] hbPeriod;
  logic [15:0] guardTime;
  logic [7:0]  lifeFactor;
  logic        tick;
  logic        hbExpired;
  logic        guardExpired;
  logic        isCmd;
  logic        doAppReset;
  logic        doCommReset;
  logic        guardReq;
  logic        hbEnabled;
  logic        guardEnabled;
  logic        bootSent;
  logic        sentFrame;
  logic [23:0] guardPeriod;
  logic        hbRestart;

  assign isCmd        = rxValid && addressedToMe(rxFrame, nodeId);
  assign doCommReset  = isCmd && (rxFrame.data0 == `CS_RESET_COMM);
  assign doAppReset   = pendAppReset && !saveBusy;
  assign hbEnabled    = (hbPeriod != 16'h0000);
  assign guardEnabled = (guardPeriod != 24'h00_0000) && !hbEnabled;
  assign guardPeriod  = 24'(guardTime * lifeFactor);
  assign guardReq     = rxValid && rxFrame.rtr &&
                        (rxFrame.id == (`ID_ERRCTL_BASE + {4'h0, nodeId}));
  assign sentFrame    = txValid && txReady;
  assign bootSent     = sentFrame && bootPending;

  ////////////////////////////////////////////////////////////////////////
  ms_tick u_tick (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .tick (tick)
  );

  ms_timer u_hb_timer (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .tick    (tick),
    .start   (bootSent || (sentFrame && hbPending) || hbRestart),
    .stop    (!hbEnabled || (state == S_INIT && !bootSent)),
    .period  ({8'h00, hbPeriod}),
    .expired (hbExpired)
  );

  ms_timer u_guard_timer (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .tick    (tick),
    .start   (guardReq && guardEnabled),
    .stop    (!guardEnabled || state == S_INIT),
    .period  (guardPeriod),
    .expired (guardExpired)
  );

  ////////////////////////////////////////////////////////////////////////
  // Network state machine
  always_comb begin
    next_state = state;
    case (state)
      S_INIT: begin
        if (bootSent) begin
          next_state = S_PREOP;
        end
      end
      S_PREOP, S_OPER, S_STOPPED: begin
        if (doCommReset || doAppReset) begin
          next_state = S_INIT;
        end else if (isCmd) begin
          case (rxFrame.data0)
            `CS_START: next_state = S_OPER;
            `CS_PREOP: next_state = S_PREOP;
            `CS_STOP:  next_state = S_STOPPED;
            default:   next_state = state;
          endcase
        end
      end
      default: next_state = S_INIT;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_INIT;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // Deferred application reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pendAppReset <= 1'b0;
    end else if (ce) begin
      if (doAppReset || state == S_INIT) begin
        pendAppReset <= 1'b0;
      end else if (isCmd && rxFrame.data0 == `CS_RESET_APP) begin
        pendAppReset <= 1'b1;
      end
    end
  end

  // Initialisation delay and announcement request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initCount   <= 5'd0;
      bootPending <= 1'b0;
    end else if (ce) begin
      if (state != S_INIT) begin
        initCount   <= 5'd0;
        bootPending <= 1'b0;
      end else if (bootSent) begin
        bootPending <= 1'b0;
      end else if (initCount == 5'(`INIT_CYCLES)) begin
        bootPending <= 1'b1;
      end else begin
        initCount <= initCount + 5'd1;
      end
    end
  end

  // Heartbeat and guarding requests; set wins over the clear by send
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hbPending    <= 1'b0;
      guardPending <= 1'b0;
    end else if (ce) begin
      if (state == S_INIT || !hbEnabled) begin
        hbPending <= 1'b0;
      end else if (hbExpired) begin
        hbPending <= 1'b1;
      end else if (sentFrame && !bootPending) begin
        hbPending <= 1'b0;
      end
      if (state == S_INIT || !guardEnabled) begin
        guardPending <= 1'b0;
      end else if (guardReq) begin
        guardPending <= 1'b1;
      end else if (sentFrame && !hbPending) begin
        guardPending <= 1'b0;
      end
    end
  end

  // Toggle flag and supervision arm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toggleFlag <= 1'b0;
      guardArmed <= 1'b0;
    end else if (ce) begin
      if (doCommReset || doAppReset) begin
        toggleFlag <= 1'b0;
        guardArmed <= 1'b0;
      end else begin
        if (sentFrame && guardPending && !hbPending && !bootPending) begin
          toggleFlag <= !toggleFlag;
        end
        if (guardReq && guardEnabled) begin
          guardArmed <= 1'b1;
        end
      end
    end
  end

  // Transmit frame; no frame answers a network command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txValid <= 1'b0;
      txFrame <= '0;
    end else if (ce) begin
      if (sentFrame) begin
        txValid <= 1'b0;
      end else if (!txValid && (bootPending || hbPending || guardPending)) begin
        txValid       <= 1'b1;
        txFrame.id    <= `ID_ERRCTL_BASE + {4'h0, nodeId};
        txFrame.rtr   <= 1'b0;
        txFrame.dlc   <= 4'h1;
        txFrame.data1 <= 8'h00;
        if (bootPending) begin
          txFrame.data0 <= 8'h00;
        end else if (hbPending) begin
          txFrame.data0 <= {1'b0, stateCode(state)};
        end else begin
          txFrame.data0 <= {toggleFlag, stateCode(state)};
        end
      end
    end
  end

  // Error-control objects
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hbPeriod   <= `HB_PERIOD_RESET;
      guardTime  <= `GUARD_RESET;
      lifeFactor <= `LIFE_RESET;
    end else if (ce && objWriteValid) begin
      case (objWrite.index)
        `OBJ_HB_PERIOD:   hbPeriod   <= objWrite.data;
        `OBJ_GUARD_TIME:  guardTime  <= objWrite.data;
        `OBJ_LIFE_FACTOR: lifeFactor <= objWrite.data[7:0];
        default:          hbPeriod   <= hbPeriod;
      endcase
    end
  end

  // Period write restarts heartbeat timing with the new value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hbRestart <= 1'b0;
    end else if (ce) begin
      hbRestart <= objWriteValid && (objWrite.index == `OBJ_HB_PERIOD);
    end
  end

  // Registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      objReadData    <= 16'h0000;
      nodeStateCode  <= `ST_BOOT;
      sdoEnable      <= 1'b0;
      pdoEnable      <= 1'b0;
      appResetPulse  <= 1'b0;
      commResetPulse <= 1'b0;
      guardError     <= 1'b0;
    end else if (ce) begin
      case (objReadIndex)
        `OBJ_HB_PERIOD:   objReadData <= hbPeriod;
        `OBJ_GUARD_TIME:  objReadData <= guardTime;
        `OBJ_LIFE_FACTOR: objReadData <= {8'h00, lifeFactor};
        default:          objReadData <= 16'h0000;
      endcase
      nodeStateCode  <= stateCode(next_state);
      sdoEnable      <= (next_state == S_PREOP) || (next_state == S_OPER);
      pdoEnable      <= (next_state == S_OPER);
      appResetPulse  <= doAppReset;
      commResetPulse <= doCommReset || doAppReset;
      if (guardExpired && guardArmed) begin
        guardError <= 1'b1;
      end else if (doCommReset || doAppReset) begin
        guardError <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** verification/nmt_master_model.sv ***
/*
  Bus master model: sends network commands and guarding polls, takes node frames.
  Assumes the node samples on the rising clock edge.
*/
`include "nmt_params.svh"
`timescale 1ns/100ps
`default_nettype none
module nmt_master_model
  import nmt_pkg::*;
#(
  parameter int GAP = 4
) (
  // Clock
  input  wire logic       clk,
  // Frames to the node
  output can_frame_t      rxFrame,
  output logic            rxValid,
  // Frames from the node
  input  wire can_frame_t txFrame,
  input  wire logic       txValid,
  output logic            txReady
);
  int         readyDelay = 0;
  int         waitCnt    = 0;
  int         txCount    = 0;
  can_frame_t lastTx     = '0;

  initial begin
    rxFrame = '0;
    rxValid = 1'b0;
  end

  task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
                      input logic [7:0] d0, input logic [7:0] d1);
    @(negedge clk);
    rxFrame = '{id, rtr, dlc, d0, d1};
    rxValid = 1'b1;
    @(negedge clk);
    rxValid = 1'b0;
    // Released bus shows no stale frame
    rxFrame = ~rxFrame;
    repeat (GAP) @(negedge clk);
  endtask

  task automatic cmd(input logic [7:0] code, input logic [7:0] node);
    send(`ID_NMT, 1'b0, 4'h2, code, node);
  endtask

  task automatic poll(input logic [6:0] node);
    send(`ID_ERRCTL_BASE + 11'(node), 1'b1, 4'h0, 8'h00, 8'h00);
  endtask

  // Slow or prompt acceptance of node frames
  always @(negedge clk) begin
    waitCnt = txValid ? waitCnt + 1 : 0;
    txReady <= txValid && waitCnt > readyDelay;
  end

  always @(posedge clk) begin
    if (txValid && txReady) begin
      lastTx  <= txFrame;
      txCount <= txCount + 1;
    end
  end
endmodule
`default_nettype wire

// *** verification/nmt_checker.sv ***
/*
  Concurrent checks of the node state machine and error-control frames.
  Assumes binding to the node top module.
*/
`include "nmt_params.svh"
`timescale 1ns/100ps
`default_nettype none
module nmt_checker
  import nmt_pkg::*;
(
  // Clock and control
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [6:0] nodeId,
  input wire logic       saveBusy,
  // Frames
  input wire can_frame_t rxFrame,
  input wire logic       rxValid,
  input wire can_frame_t txFrame,
  input wire logic       txValid,
  input wire logic       txReady,
  // State
  input wire logic [6:0] nodeStateCode,
  input wire logic       sdoEnable,
  input wire logic       pdoEnable,
  input wire logic       appResetPulse
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_nmt;
    ce && rxValid && rxFrame.id == `ID_NMT && !rxFrame.rtr && rxFrame.dlc == 4'h2;
  endsequence
  sequence s_cmd(code);
    s_nmt and (rxFrame.data0 == code && nodeStateCode != `ST_BOOT
      && (rxFrame.data1 == 8'h00 || rxFrame.data1 == {1'b0, nodeId}));
  endsequence
  sequence s_foreign;
    s_nmt and (rxFrame.data1 != 8'h00 && rxFrame.data1 != {1'b0, nodeId});
  endsequence
  sequence s_boot_taken;
    ce && txValid && txReady && nodeStateCode == `ST_BOOT;
  endsequence

  a_start_oper: assert property (s_cmd(`CS_START) |=> nodeStateCode == `ST_OPER)
    else $error("start command missed");
  a_stop_state: assert property (s_cmd(`CS_STOP) |=> nodeStateCode == `ST_STOPPED)
    else $error("stop command missed");
  a_preop_state: assert property (s_cmd(`CS_PREOP) |=> nodeStateCode == `ST_PREOP)
    else $error("preop command missed");
  a_foreign_ignored: assert property (s_foreign |=> $stable(nodeStateCode))
    else $error("foreign command acted on");
  a_pdo_oper: assert property (pdoEnable |-> nodeStateCode == `ST_OPER)
    else $error("process data outside operational");
  a_stop_quiet: assert property (nodeStateCode == `ST_STOPPED |-> !sdoEnable && !pdoEnable)
    else $error("traffic enabled while stopped");
  a_preop_sdo: assert property (nodeStateCode == `ST_PREOP |-> sdoEnable && !pdoEnable)
    else $error("wrong enables in preop");
  a_tx_layout: assert property (txValid |-> txFrame.id == `ID_ERRCTL_BASE + 11'(nodeId)
    && txFrame.dlc == 4'h1 && !txFrame.rtr)
    else $error("bad transmit frame layout");
  a_tx_state: assert property (txValid |-> txFrame.data0[6:0] == nodeStateCode)
    else $error("state byte wrong");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txFrame))
    else $error("transmit frame not held");
  a_boot_preop: assert property (s_boot_taken |=> nodeStateCode == `ST_PREOP)
    else $error("no preop after announcement");
  a_app_wait: assert property (saveBusy && $past(saveBusy) |-> !appResetPulse)
    else $error("application reset during save");
endmodule
bind canopen_nmt_error_control nmt_checker chk_u (.clk(clk), .rst(rst), .ce(ce),
  .nodeId(nodeId), .saveBusy(saveBusy), .rxFrame(rxFrame), .rxValid(rxValid),
  .txFrame(txFrame), .txValid(txValid), .txReady(txReady), .nodeStateCode(nodeStateCode),
  .sdoEnable(sdoEnable), .pdoEnable(pdoEnable), .appResetPulse(appResetPulse));
`default_nettype wire

// *** verification/tb.sv ***
/*
  Self-checking bench of the network-state and error-control block.
  Assumes the master model and checker are compiled first.
*/
`include "nmt_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb
  import nmt_pkg::*;
;
  localparam logic [6:0] NODE = 7'h2A;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, saveBusy = 1'b0;
  can_frame_t  rxFrame, txFrame;
  obj_write_t  objWrite = '0;
  logic        objWriteValid = 1'b0;
  logic [15:0] objReadIndex = `OBJ_HB_PERIOD;
  logic [15:0] objReadData;
  logic        rxValid, txValid, txReady, sdoEnable, pdoEnable;
  logic        appResetPulse, commResetPulse, guardError;
  logic [6:0]  nodeStateCode;
  int          fail_count = 0, check_count = 0;
  int          commPulses = 0, appPulses = 0;

  nmt_master_model mst_u (.clk(clk), .rxFrame(rxFrame), .rxValid(rxValid),
    .txFrame(txFrame), .txValid(txValid), .txReady(txReady));
  canopen_nmt_error_control dut_u (.clk(clk), .rst(rst), .ce(ce), .nodeId(NODE),
    .saveBusy(saveBusy), .rxFrame(rxFrame), .rxValid(rxValid), .objWrite(objWrite),
    .objWriteValid(objWriteValid), .objReadIndex(objReadIndex), .objReadData(objReadData),
    .txFrame(txFrame), .txValid(txValid), .txReady(txReady), .nodeStateCode(nodeStateCode),
    .sdoEnable(sdoEnable), .pdoEnable(pdoEnable), .appResetPulse(appResetPulse),
    .commResetPulse(commResetPulse), .guardError(guardError));

  initial forever #10 clk = ~clk;

  // Count the one-cycle reset pulses
  always @(posedge clk) begin
    if (commResetPulse) commPulses++;
    if (appResetPulse) appPulses++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_tx(input int c0, input int lim, output logic got);
    for (int i = 0; i < lim && mst_u.txCount == c0; i++) @(posedge clk);
    @(negedge clk);
    got = (mst_u.txCount != c0);
  endtask

  task automatic obj_wr(input logic [15:0] index, input logic [15:0] data);
    @(negedge clk);
    objWrite = '{index, data};
    objWriteValid = 1'b1;
    @(negedge clk);
    objWriteValid = 1'b0;
  endtask

  task automatic boot_seen();
    logic got;
    wait_tx(mst_u.txCount, 200, got);
    repeat (2) @(negedge clk);
    check(16'(got), 16'h0001);
    check(16'(mst_u.lastTx.id), 16'(`ID_ERRCTL_BASE + 11'(NODE)));
    check(16'(mst_u.lastTx.dlc), 16'h0001);
    check(16'(mst_u.lastTx.data0), 16'h0000);
    check(16'(nodeStateCode), 16'h007F);
  endtask

  task automatic t_boot();
    check(16'(nodeStateCode), 16'h0000);
    check(objReadData, 16'h0000);
    mst_u.readyDelay = 3;
    boot_seen();
    mst_u.readyDelay = 0;
    $display("test boot done");
  endtask

  task automatic t_cmds();
    logic [7:0] code [7] = '{8'h01, 8'h02, 8'h01, 8'h80, 8'h02, 8'h80, 8'h01};
    logic [7:0] node [7] = '{8'h2A, 8'h00, 8'h2A, 8'h00, 8'h2A, 8'h00, 8'h2B};
    logic [6:0] exp  [7] = '{7'h05, 7'h04, 7'h05, 7'h7F, 7'h04, 7'h7F, 7'h7F};
    for (int i = 0; i < 7; i++) begin
      mst_u.cmd(code[i], node[i]);
      check(16'(nodeStateCode), 16'(exp[i]));
      check(16'(pdoEnable), 16'(exp[i] == 7'h05));
      check(16'(sdoEnable), 16'(exp[i] != 7'h04));
      check(16'(txValid), 16'h0000);
    end
    $display("test commands done");
  endtask

  task automatic t_guard();
    logic got;
    int   c0;
    obj_wr(`OBJ_GUARD_TIME, 16'h0001);
    obj_wr(`OBJ_LIFE_FACTOR, 16'h0001);
    objReadIndex = `OBJ_GUARD_TIME;
    repeat (2) @(negedge clk);
    check(objReadData, 16'h0001);
    objReadIndex = `OBJ_HB_PERIOD;
    check(16'(guardError), 16'h0000);
    for (int i = 0; i < 2; i++) begin
      c0 = mst_u.txCount;
      mst_u.poll(NODE);
      wait_tx(c0, 50, got);
      check(16'(got), 16'h0001);
      check(16'(mst_u.lastTx.data0), {8'h00, i[0], 7'h7F});
    end
    mst_u.cmd(`CS_RESET_COMM, 8'h00);
    boot_seen();
    check(16'(commPulses), 16'h0001);
    c0 = mst_u.txCount;
    mst_u.poll(NODE);
    wait_tx(c0, 50, got);
    check(16'(mst_u.lastTx.data0), 16'h007F);
    check(16'(guardError), 16'h0000);
    // No further poll: supervision must time out within one millisecond
    for (int i = 0; i < 52000 && !guardError; i++) @(negedge clk);
    check(16'(guardError), 16'h0001);
    $display("test guarding done");
  endtask

  task automatic t_app();
    logic got;
    int   c0;
    @(negedge clk);
    saveBusy = 1'b1;
    c0 = mst_u.txCount;
    mst_u.cmd(`CS_RESET_APP, {1'b0, NODE});
    wait_tx(c0, 60, got);
    check(16'(got), 16'h0000);
    check(16'(nodeStateCode), 16'h007F);
    saveBusy = 1'b0;
    boot_seen();
    check(16'(appPulses), 16'h0001);
    check(16'(commPulses), 16'h0002);
    check(16'(guardError), 16'h0000);
    $display("test app reset done");
  endtask

  task automatic t_heart();
    logic got;
    int   c0;
    obj_wr(`OBJ_HB_PERIOD, 16'h0001);
    @(negedge clk);
    check(objReadData, 16'h0001);
    mst_u.cmd(`CS_START, {1'b0, NODE});
    c0 = mst_u.txCount;
    mst_u.poll(NODE);
    wait_tx(c0, 20, got);
    check(16'(got), 16'h0000);
    wait_tx(c0, 52000, got);
    check(16'(got), 16'h0001);
    check(16'(mst_u.lastTx.data0), 16'h0005);
    $display("test heartbeat done");
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_boot();
    t_cmds();
    t_guard();
    t_app();
    t_heart();
    tally_and_finish();
  end

  // Watchdog just above the two one-millisecond waits
  initial begin
    repeat (110000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
